//--- design/iec_pkg.sv
// Constants, types and register map of the interrupt and event-transfer block.
// Assumes a single 20 MHz clock and an APB master with 12-bit byte addresses.
package iec_pkg;

    // ----------------------------------------
    // Sizes
    // ----------------------------------------
    localparam int NSRC = 16;
    localparam int NCH  = 8;
    localparam int NEXT = 4;

    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [11:0] A_SRC  = 12'h000;
    localparam logic [11:0] A_CHC  = 12'h040;
    localparam logic [11:0] A_CHS  = 12'h060;
    localparam logic [11:0] A_CHD  = 12'h080;
    localparam logic [11:0] A_EDGE = 12'h0A0;
    localparam logic [11:0] A_STAT = 12'h0A4;
    localparam logic [11:0] A_MASK = 12'h0A8;
    localparam logic [11:0] A_CORE = 12'h0AC;

    // ----------------------------------------
    // Reset values and fixed figures
    // ----------------------------------------
    localparam logic [11:0] SRC_RST  = 12'h000;
    localparam logic [15:0] CHC_RST  = 16'h0000;
    localparam logic [23:0] PTR_RST  = 24'h000000;
    localparam logic [7:0]  EDGE_RST = 8'h00;
    localparam logic [7:0]  EV_RST   = 8'h00;
    localparam logic [6:0]  VEC_BASE = 7'h18;
    localparam int RESP_MIN_CLK = 5;
    localparam int RESP_MAX_CLK = 12;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_READ  = 4'h2,
        ST_WRITE = 4'h4,
        ST_OFFER = 4'h8
    } iec_state_type;

    typedef struct packed {
        logic [2:0] chan;
        logic       ev;
        logic       req;
        logic       en;
        logic [1:0] pad;
        logic [3:0] level;
    } iec_src_type;

    typedef struct packed {
        logic [7:0] cnt;
        logic [4:0] pad;
        logic       cont;
        logic       inc_dst;
        logic       word;
    } iec_chc_type;

    typedef struct packed {
        logic [23:0] addr;
        logic [15:0] wdata;
        logic        en;
        logic        we;
        logic        word;
    } iec_mem_type;

    typedef struct packed {
        logic        req;
        logic [3:0]  level;
        logic [23:0] vec_addr;
    } iec_offer_type;

endpackage : iec_pkg

//--- design/iec_ctrl.sv
// Interrupt controller with eight event-transfer channels, APB register slave.
// Assumes memory answers a read in the same cycle and takes a write at the edge.
//
// Behaviour
// R1 - Accepted requests are offered to the core within a few clocks of arrival.
// R2 - Each source selects standard interrupt or event-transfer service by a bit.
// R3 - Standard service offers the source's vector so the core branches there.
// R4 - Event transfer stalls the core for exactly one machine cycle, no vector.
// R5 - Each transfer moves one byte or one word between any two addresses.
// R6 - After each transfer the source or destination pointer is incremented.
// R7 - The channel counter decrements per transfer unless continuous mode is set.
// R8 - When the counter reaches zero, the source gets a standard interrupt.
// R9 - Eight independent channels, each with own pointers and counter.
// R10 - Each source has a control register with request, enable and level.
// R11 - The level field is four bits, selecting one of sixteen levels.
// R12 - Only a level strictly above the running service may preempt it.
// R13 - Every source has its own vector location.
// R14 - Fast inputs detect rising, falling or both edges and set the request.
// R15 - Trap instruction number selects the vector to enter.
// R16 - Software writing one to a request bit raises that request.
// R17 - Highest level wins arbitration; request flag clears when service accepted.
`timescale 1ns/100ps
module iec_ctrl
    import iec_pkg::*;
(
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          rst,
    // APB slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    // Requesting sources
    input  wire logic [15:0]   periph_req,
    input  wire logic [3:0]    ext_pin,
    // CPU core
    input  wire logic [3:0]    cpu_level,
    input  wire logic          cpu_ack,
    input  wire logic          trap_valid,
    input  wire logic [6:0]    trap_num,
    output iec_offer_type      offer,
    output logic               trap_vec_valid,
    output logic [23:0]        trap_vec_addr,
    output logic               cpu_stall,
    // Memory port for transfers
    output iec_mem_type        mem,
    input  wire logic [15:0]   mem_rdata,
    // Summary interrupt
    output logic               irq
);

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    iec_src_type   src [NSRC];
    iec_chc_type   chc [NCH];
    logic [23:0]   chs [NCH];
    logic [23:0]   chd [NCH];
    logic [7:0]    edge_sel;
    logic [7:0]    ev_stat;
    logic [7:0]    ev_mask;
    logic [3:0]    pin_prev;
    iec_state_type state;
    iec_state_type next_state;
    logic [3:0]    cur_idx;
    logic [2:0]    cur_ch;

    function automatic logic [23:0] step(input logic word);
        step = word ? 24'h000002 : 24'h000001;
    endfunction : step

    function automatic logic [23:0] vec_of(input logic [6:0] num);
        vec_of = {15'h0, num, 2'h0};
    endfunction : vec_of

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    wire        setup   = psel & ~penable;
    wire        wr_fire = psel & penable & pready & pwrite & ~pslverr;
    wire [3:0]  a_src   = paddr[5:2];
    wire [2:0]  a_ch    = paddr[4:2];
    wire        sel_src = paddr[11:6] == A_SRC[11:6];
    wire        sel_chc = paddr[11:5] == A_CHC[11:5];
    wire        sel_chs = paddr[11:5] == A_CHS[11:5];
    wire        sel_chd = paddr[11:5] == A_CHD[11:5];
    wire        sel_edg = paddr == A_EDGE;
    wire        sel_st  = paddr == A_STAT;
    wire        sel_msk = paddr == A_MASK;
    wire        sel_cor = paddr == A_CORE;
    wire        map_ok  = sel_src | sel_chc | sel_chs | sel_chd |
                          sel_edg | sel_st | sel_msk | sel_cor;

    logic [31:0] rd_val;
    always_comb begin
        rd_val = 32'h00000000;
        if (sel_src) begin
            rd_val = {20'h00000, src[a_src]};
        end else if (sel_chc) begin
            rd_val = {16'h0000, chc[a_ch]};
        end else if (sel_chs) begin
            rd_val = {8'h00, chs[a_ch]};
        end else if (sel_chd) begin
            rd_val = {8'h00, chd[a_ch]};
        end else if (sel_edg) begin
            rd_val = {24'h000000, edge_sel};
        end else if (sel_st) begin
            rd_val = {24'h000000, ev_stat};
        end else if (sel_msk) begin
            rd_val = {24'h000000, ev_mask};
        end else if (sel_cor) begin
            rd_val = {21'h0, state, cur_idx, cur_ch};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~map_ok;
            if (setup) begin
                prdata <= rd_val;
            end
        end
    end

    // ----------------------------------------
    // Fast external edge detection
    // ----------------------------------------
    logic [15:0] ext_hit;
    always_comb begin
        ext_hit = 16'h0000;
        for (int e = 0; e < NEXT; e++) begin
            ext_hit[e] = (edge_sel[2*e]   &  ext_pin[e] & ~pin_prev[e]) |
                         (edge_sel[2*e+1] & ~ext_pin[e] &  pin_prev[e]);   // R14
        end
    end

    // ----------------------------------------
    // Arbitration
    // ----------------------------------------
    logic [3:0] win_idx;
    logic [3:0] win_lvl;
    logic       win_ok;
    always_comb begin
        win_idx = 4'h0;
        win_lvl = 4'h0;
        win_ok  = 1'b0;
        for (int i = 0; i < NSRC; i++) begin
            if (src[i].req && src[i].en && src[i].level > cpu_level &&   // R12
                (!win_ok || src[i].level > win_lvl)) begin                // R17
                win_ok  = 1'b1;
                win_lvl = src[i].level;                                  // R11
                win_idx = 4'(i);
            end
        end
    end

    wire        win_ev  = src[win_idx].ev;                               // R2
    wire [2:0]  win_ch  = src[win_idx].chan;
    wire        in_wr   = state == ST_WRITE;
    wire        acc_std = (state == ST_OFFER) & cpu_ack;
    wire        acc_ev  = (state == ST_IDLE) & win_ok & win_ev;
    wire [3:0]  acc_idx = acc_ev ? win_idx : cur_idx;
    wire        acc_any = acc_std | acc_ev;
    wire        cur_cont = chc[cur_ch].cont;
    wire        tc_now  = in_wr & ~cur_cont & (chc[cur_ch].cnt == 8'h01);

    // ----------------------------------------
    // Service sequencer
    // ----------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (win_ok) begin
                    next_state = win_ev ? ST_READ : ST_OFFER;
                end
            end
            ST_READ: begin
                next_state = ST_WRITE;                                   // R4
            end
            ST_WRITE: begin
                next_state = ST_IDLE;
            end
            ST_OFFER: begin
                // A new winner or a withdrawn one forces a fresh round
                if (cpu_ack || !win_ok || win_idx != cur_idx) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state   <= ST_IDLE;
            cur_idx <= 4'h0;
            cur_ch  <= 3'h0;
        end else begin
            state <= next_state;
            if (state == ST_IDLE && win_ok) begin
                cur_idx <= win_idx;
                cur_ch  <= win_ch;
            end
        end
    end

    // ----------------------------------------
    // Core and memory outputs
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            offer          <= '0;
            mem            <= '0;
            cpu_stall      <= 1'b0;
            trap_vec_valid <= 1'b0;
            trap_vec_addr  <= PTR_RST;
        end else begin
            offer.req   <= next_state == ST_OFFER;                       // R1
            cpu_stall   <= next_state == ST_READ || next_state == ST_WRITE; // R4
            mem.en      <= next_state == ST_READ || next_state == ST_WRITE;
            mem.we      <= next_state == ST_WRITE;
            if (state == ST_IDLE && win_ok) begin
                offer.level    <= win_lvl;
                offer.vec_addr <= vec_of(VEC_BASE + 7'(win_idx));        // R3 R13
                mem.addr       <= chs[win_ch];                           // R5
                mem.word       <= chc[win_ch].word;
            end
            if (state == ST_READ) begin
                mem.addr  <= chd[cur_ch];
                mem.wdata <= chc[cur_ch].word ? mem_rdata : {8'h00, mem_rdata[7:0]}; // R5
            end
            trap_vec_valid <= trap_valid;
            if (trap_valid) begin
                trap_vec_addr <= vec_of(trap_num);                       // R15
            end
        end
    end

    // ----------------------------------------
    // Source control registers
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < NSRC; i++) begin
                src[i] <= SRC_RST;
            end
            pin_prev <= 4'h0;
        end else begin
            pin_prev <= ext_pin;
            for (int i = 0; i < NSRC; i++) begin
                // Hardware set beats both acceptance and a software clear
                if (wr_fire && sel_src && a_src == 4'(i)) begin
                    src[i]     <= pwdata[11:0];                          // R10
                    src[i].pad <= 2'h0;
                    if (periph_req[i] || ext_hit[i] || (tc_now && cur_idx == 4'(i))) begin
                        src[i].req <= 1'b1;
                    end
                end else if (periph_req[i] || ext_hit[i] ||
                             (tc_now && cur_idx == 4'(i))) begin
                    src[i].req <= 1'b1;                                  // R14 R8
                end else if (acc_any && acc_idx == 4'(i)) begin
                    src[i].req <= 1'b0;                                  // R17
                end
                if (tc_now && cur_idx == 4'(i)) begin
                    src[i].ev <= 1'b0;                                   // R8
                end
            end
        end
    end

    // ----------------------------------------
    // Transfer channels
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int c = 0; c < NCH; c++) begin
                chc[c] <= CHC_RST;
                chs[c] <= PTR_RST;
                chd[c] <= PTR_RST;
            end
        end else begin
            for (int c = 0; c < NCH; c++) begin                          // R9
                if (in_wr && cur_ch == 3'(c)) begin
                    if (chc[c].inc_dst) begin
                        chd[c] <= chd[c] + step(chc[c].word);            // R6
                    end else begin
                        chs[c] <= chs[c] + step(chc[c].word);            // R6
                    end
                    if (!chc[c].cont) begin
                        chc[c].cnt <= chc[c].cnt - 8'h01;                // R7
                    end
                end else if (wr_fire) begin
                    if (sel_chc && a_ch == 3'(c)) begin
                        chc[c]     <= pwdata[15:0];
                        chc[c].pad <= 5'h00;
                    end
                    if (sel_chs && a_ch == 3'(c)) begin
                        chs[c] <= pwdata[23:0];
                    end
                    if (sel_chd && a_ch == 3'(c)) begin
                        chd[c] <= pwdata[23:0];
                    end
                end
            end
        end
    end

    // ----------------------------------------
    // Event status, mask and summary interrupt
    // ----------------------------------------
    wire [7:0] tc_bits = tc_now ? (8'h01 << cur_ch) : 8'h00;

    always_ff @(posedge clk) begin
        if (rst) begin
            edge_sel <= EDGE_RST;
            ev_stat  <= EV_RST;
            ev_mask  <= EV_RST;
            irq      <= 1'b0;
        end else begin
            if (wr_fire && sel_edg) begin
                edge_sel <= pwdata[7:0];
            end
            if (wr_fire && sel_msk) begin
                ev_mask <= pwdata[7:0];
            end
            // New terminal counts survive a same-cycle write-one clear
            if (wr_fire && sel_st) begin
                ev_stat <= (ev_stat & ~pwdata[7:0]) | tc_bits;
            end else begin
                ev_stat <= ev_stat | tc_bits;
            end
            irq <= |(ev_stat & ev_mask);
        end
    end

endmodule : iec_ctrl

//--- tb/iec_ctrl_asserts.sv
// Port checks for the interrupt and event-transfer block.
// Assumes the bind below reaches every instance of the block.
`timescale 1ns/100ps
module iec_ctrl_asserts
    import iec_pkg::*;
(
    // Clock and reset
    input wire logic          clk,
    input wire logic          rst,
    // APB
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pready,
    input wire logic          pslverr,
    // Core and memory side
    input wire logic [3:0]    cpu_level,
    input wire logic          cpu_ack,
    input wire logic          trap_valid,
    input wire logic [6:0]    trap_num,
    input wire iec_offer_type offer,
    input wire logic          trap_vec_valid,
    input wire logic [23:0]   trap_vec_addr,
    input wire logic          cpu_stall,
    input wire iec_mem_type   mem
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_apb_answer: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_err_in_access: assert property (pslverr |-> pready && psel && penable)
        else $error("error outside access");
    a_trap_vector: assert property (trap_valid |=> trap_vec_valid &&
        trap_vec_addr == {15'h0, $past(trap_num), 2'b00})
        else $error("trap vector wrong");
    a_offer_vector: assert property (offer.req |-> offer.vec_addr[1:0] == 2'b00 &&
        offer.vec_addr >= 24'h000060 && offer.vec_addr <= 24'h00009C)
        else $error("vector out of table");
    a_ack_clears: assert property (offer.req && cpu_ack |=> !offer.req)
        else $error("offer kept after ack");
    a_offer_above: assert property ($rose(offer.req) |-> offer.level > $past(cpu_level))
        else $error("offer not above level");
    a_stall_once: assert property ($rose(cpu_stall) |-> mem.en && !mem.we
        ##1 cpu_stall && mem.en && mem.we ##1 !cpu_stall)
        else $error("transfer not one cycle");
    a_no_vec_stall: assert property (cpu_stall |-> !offer.req)
        else $error("vector during transfer");
    a_byte_zero: assert property (mem.en && mem.we && !mem.word |-> mem.wdata[15:8] == 8'h00)
        else $error("byte write not extended");
endmodule : iec_ctrl_asserts

bind iec_ctrl iec_ctrl_asserts iec_ctrl_asserts_i (.clk, .rst, .psel, .penable, .pready,
    .pslverr, .cpu_level, .cpu_ack, .trap_valid, .trap_num, .offer, .trap_vec_valid,
    .trap_vec_addr, .cpu_stall, .mem);

//--- tb/iec_mem_model.sv
// Memory behind the transfer port, answering a read in the same cycle.
// Assumes the block samples read data at the end of the read cycle.
`timescale 1ns/100ps
module iec_mem_model
    import iec_pkg::*;
(
    // Transfer port
    input wire iec_mem_type mem,
    output logic [15:0]     mem_rdata
);
    // Inverted outside reads so a sample in the wrong cycle cannot match
    assign mem_rdata = (mem.en && !mem.we) ? mem.addr[15:0] ^ 16'h5A3C
                                           : ~(mem.addr[15:0] ^ 16'h5A3C);
endmodule : iec_mem_model

//--- tb/iec_ctrl_tb.sv
// Self-checking bench for the interrupt and event-transfer block.
// Assumes the checker is bound and the memory model answers transfers.
`timescale 1ns/100ps
module iec_ctrl_tb;
    import iec_pkg::*;
    logic          clk, rst, psel, penable, pwrite, cpu_ack, trap_valid, err, w, d;
    logic          pready, pslverr, trap_vec_valid, cpu_stall, irq;
    logic [11:0]   paddr;
    logic [31:0]   pwdata, prdata, q;
    logic [15:0]   periph_req, mem_rdata;
    logic [3:0]    ext_pin, cpu_level, lv;
    logic [6:0]    trap_num;
    logic [23:0]   trap_vec_addr, sp, dp;
    logic [1:0]    m;
    iec_offer_type offer;
    iec_mem_type   mem;
    int            mismatches, total_checks, n, c;

    iec_ctrl iec_ctrl_i (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .periph_req, .ext_pin, .cpu_level, .cpu_ack, .trap_valid,
        .trap_num, .offer, .trap_vec_valid, .trap_vec_addr, .cpu_stall, .mem, .mem_rdata,
        .irq);
    iec_mem_model iec_mem_model_i (.mem, .mem_rdata);

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    function automatic logic [15:0] pat(input logic [23:0] a);
        return a[15:0] ^ 16'h5A3C;
    endfunction : pat

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] dt);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= dt;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, q);
    endtask : rd

    // Waits for the offer, checks it, then accepts it
    task automatic take_offer(input int s, input logic [3:0] lev);
        // Let the previous acceptance retire before looking at the offer again
        @(posedge clk);
        for (n = 0; offer.req !== 1'b1 && n < 20; n++) @(posedge clk);
        chk("resp", 1, n <= RESP_MAX_CLK);
        chk("vec", 32'((24 + s) * 4), {8'h00, offer.vec_addr});
        chk("level", lev, offer.level);
        cpu_ack <= 1'b1;
        @(posedge clk);
        cpu_ack <= 1'b0;
    endtask : take_offer

    task automatic xfer(input int ch);
        periph_req <= 16'(1) << (4 + ch);
        @(posedge clk);
        periph_req <= 16'h0000;
        for (n = 0; mem.en !== 1'b1 && n < 20; n++) @(posedge clk);
        chk("rd_addr", sp, mem.addr);
        chk("rd_kind", {28'h0, 3'b110, w}, {28'h0, mem.en, cpu_stall, mem.we, mem.word});
        @(posedge clk);
        chk("wr_addr", {8'h01, dp}, {7'h0, mem.we, mem.addr});
        chk("wr_data", pat(sp) & {{8{w}}, 8'hFF}, mem.wdata);
        if (d) dp = dp + 24'(w ? 2 : 1);
        else sp = sp + 24'(w ? 2 : 1);
    endtask : xfer

    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (30000) @(posedge clk);
        mismatches++;
        finish_test;
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        {rst, psel, penable, pwrite, cpu_ack, trap_valid} = 6'b100000;
        {paddr, pwdata, periph_req, ext_pin, cpu_level, trap_num} = '0;
        void'($urandom(32'h19100A87));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd("src_rst", A_SRC, 32'h0);
        rd("core_rst", A_CORE, 32'h00000080);
        rd("unmapped", 12'h0FC, 32'h0);
        chk("slverr", 1, err);
        $display("test reset done");
        for (int i = 0; i < NSRC; i++) begin
            lv = 4'($urandom_range(15, 1));
            apb(1'b1, A_SRC + 12'(4 * i), {24'h0, 4'hC, lv});
            take_offer(i, lv);
            rd("req_clr", A_SRC + 12'(4 * i), {24'h0, 4'h4, lv});
            apb(1'b1, A_SRC + 12'(4 * i), 32'h0);
        end
        $display("test software requests done");
        cpu_level <= 4'h5;
        apb(1'b1, A_SRC + 12'h030, 32'h000000C5);
        apb(1'b1, A_SRC + 12'h038, 32'h00000049);
        apb(1'b1, A_SRC + 12'h034, 32'h000000C9);
        periph_req <= 16'h4000;
        @(posedge clk);
        periph_req <= 16'h0000;
        take_offer(13, 4'h9);
        take_offer(14, 4'h9);
        repeat (6) @(posedge clk);
        chk("no_preempt", 0, offer.req);
        cpu_level <= 4'h0;
        take_offer(12, 4'h5);
        $display("test priority done");
        for (int e = 0; e < NEXT; e++) begin
            m = 2'(e % 3 + 1);
            apb(1'b1, A_EDGE, 32'(m) << (2 * e));
            ext_pin <= 4'(1) << e;
            repeat (4) @(posedge clk);
            rd("edge_rise", A_SRC + 12'(4 * e), 32'(m[0]) << 7);
            apb(1'b1, A_SRC + 12'(4 * e), 32'h0);
            ext_pin <= 4'h0;
            repeat (4) @(posedge clk);
            rd("edge_fall", A_SRC + 12'(4 * e), 32'(m[1]) << 7);
            apb(1'b1, A_SRC + 12'(4 * e), 32'h0);
        end
        $display("test edges done");
        for (int t = 0; t < 2; t++) begin
            c = (t == 0) ? $urandom_range(7) : (c + 1) % NCH;
            {w, d} = 2'($urandom);
            sp = 24'($urandom);
            dp = 24'($urandom);
            apb(1'b1, A_CHS + 12'(4 * c), {8'h0, sp});
            apb(1'b1, A_CHD + 12'(4 * c), {8'h0, dp});
            apb(1'b1, A_CHC + 12'(4 * c), {16'h0, 8'(2 - t), 5'h0, t[0], d, w});
            apb(1'b1, A_SRC + 12'(16 + 4 * c), {20'h0, 3'(c), 5'h14, 4'(1 + t)});
            for (int k = 0; k < 2 - t; k++) begin
                xfer(c);
            end
            rd("count", A_CHC + 12'(4 * c), {16'h0, 8'(t), 5'h0, t[0], d, w});
            rd("src_ptr", A_CHS + 12'(4 * c), {8'h0, sp});
            rd("dst_ptr", A_CHD + 12'(4 * c), {8'h0, dp});
            rd("status", A_STAT, 32'(1) << ((c + 7 * t) % NCH));
        end
        c = (c + 7) % NCH;
        chk("irq_masked", 0, irq);
        apb(1'b1, A_MASK, 32'(1) << c);
        repeat (2) @(posedge clk);
        chk("irq_set", 1, irq);
        take_offer(4 + c, 4'h1);
        apb(1'b1, A_STAT, 32'(1) << c);
        repeat (2) @(posedge clk);
        chk("irq_clr", 0, irq);
        $display("test transfers done");
        for (int i = 0; i < 4; i++) begin
            trap_num   <= 7'($urandom);
            trap_valid <= 1'b1;
            @(posedge clk);
            trap_valid <= 1'b0;
            @(posedge clk);
            chk("trap", {8'h01, 15'h0, trap_num, 2'b00}, {7'h0, trap_vec_valid, trap_vec_addr});
        end
        $display("test traps done");
        finish_test;
    end
endmodule : iec_ctrl_tb
